// ===== bcr_pkg.sv
// bcr_pkg: shared constants for the burst and front-end configuration bank
// assumes a 200 MHz core clock and a 32-bit Avalon-MM register port
package bcr_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_GAIN5 = 8'h1A;
	localparam logic [7:0] IDX_START_GAIN = 8'h1B;
	localparam logic [7:0] IDX_TONE = 8'h1C;
	localparam logic [7:0] IDX_GAP = 8'h1D;
	localparam logic [7:0] IDX_PRESET1 = 8'h1E;
	localparam logic [7:0] IDX_PRESET2 = 8'h1F;
	localparam int ADDR_W = 8;
	localparam int REG_W = 8;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ==========================================================
	// field positions
	localparam int GAIN5_LSB = 2;
	localparam int GAIN5_MSB = 7;
	localparam int SHIFT_BIT = 0;
	localparam int BW_LSB = 6;
	localparam int BW_MSB = 7;
	localparam int START_LSB = 0;
	localparam int START_MSB = 5;
	localparam int FILT_LSB = 4;
	localparam int FILT_MSB = 7;
	localparam int GAPC_LSB = 0;
	localparam int GAPC_MSB = 3;
	localparam int IFSEL_BIT = 7;
	localparam int DIAG_BIT = 6;
	localparam int XOFF_BIT = 5;
	localparam int PULSE_LSB = 0;
	localparam int PULSE_MSB = 4;
	localparam int NODE_LSB = 5;
	localparam int NODE_MSB = 7;

	// ==========================================================
	// tone arithmetic in units of 100 Hz: 0.2 kHz per step, 30 kHz base
	localparam logic [12:0] TONE_STEP_DHZ = 13'h0002;
	localparam logic [12:0] TONE_BASE_DHZ = 13'h012C;
	localparam logic [12:0] TONE_SHIFT_MUL = 13'h0006;
	localparam logic [7:0] TONE_CODE_MAX = 8'hFA;
	// bandwidth is 2 kHz per step plus one
	localparam logic [3:0] BW_STEP_KHZ = 4'h2;

	// ==========================================================
	// timing: steps in picoseconds, cycles derived from the clock
	localparam int CLK_PERIOD_PS = 5000;
	localparam int FILT_STEP_PS = 8000000;
	localparam int GAP_STEP_PS = 62500;

	// least time: round up to whole cycles
	function automatic logic [15:0] ps_to_cycles(input int unsigned ps);
		int unsigned c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return c[15:0];
	endfunction : ps_to_cycles

	localparam logic [15:0] FILT_STEP_CYC = ps_to_cycles(FILT_STEP_PS);

endpackage : bcr_pkg

// ===== bcr_pulse_decode.sv
// bcr_pulse_decode: turns a preset pulse-count field into a pulse count
// assumes the field comes from a register on the same clock
`timescale 1ns/1ps
module bcr_pulse_decode
	import bcr_pkg::*;
#(
	parameter int CNT_W = 5
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// field in
	input wire logic [CNT_W-1:0] count_field,
	// decoded
	output logic [CNT_W-1:0] pulses_r,
	output logic single_first_r
);

	// ==========================================================
	// checks
	if (CNT_W != PULSE_MSB - PULSE_LSB + 1)
	begin : g_bad_width
		$error("pulse field width mismatch");
	end

	// ==========================================================
	// decode: zero means one lone pulse on the first driver only
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pulses_r <= '0;
			single_first_r <= 1'b0;
		end
		else
		begin
			single_first_r <= (count_field == '0); // see [RULE14]
			pulses_r <= (count_field == '0) ? CNT_W'(1) : count_field;
		end
	end

endmodule : bcr_pulse_decode

// ===== bcr_regs.sv
// bcr_regs: burst and front-end configuration register bank
// assumes an Avalon-MM master on CLOCK; settings go to burst and AFE logic
//
// Contract
// [RULE1] bits 7:2 of gain5 register give point-five gain, half-dB steps plus one
// [RULE2] range shift set multiplies the computed burst tone by six
// [RULE3] bits 7:6 of start-gain register set bandpass width 2 kHz times (n+1)
// [RULE4] bits 5:0 of start-gain register give initial gain, half-dB times (n+1)
// [RULE5] burst tone equals 0.2 kHz times code plus 30 kHz
// [RULE6] software writes tone codes from 0 to 250 only
// [RULE7] comparator filter period is bits 7:4 times 8 microseconds
// [RULE8] pulse gap is bits 3:0 times 0.0625 microseconds
// [RULE9] preset1 bit 7 picks time-based (0) or one-wire serial (1) pin protocol
// [RULE10] preset1 bit 6 picks serial (0) or system (1) diagnostic page
// [RULE11] preset1 bit 5 set turns pin transceiver off, clear turns it on
// [RULE12] transceiver off bit acts only while time-based interface selected
// [RULE13] preset1 bits 4:0 set preset one burst pulse count
// [RULE14] pulse count zero means one single pulse on first driver only
// [RULE15] preset2 bits 4:0 set preset two pulse count, same zero meaning
// [RULE16] preset2 bits 7:5 hold the serial node address, reset zero
// [RULE17] all six registers reset to zero and read back as written
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module bcr_regs
	import bcr_pkg::*;
#(
	parameter int DATA_W = 32
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [DATA_W-1:0] WRITEDATA,
	input wire logic [DATA_W/8-1:0] BYTEENABLE,
	output logic [DATA_W-1:0] READDATA,
	output logic WAITREQUEST,
	// receive gain settings in half-dB units above the range offset, bandpass width in kHz
	output logic [6:0] GAIN_POINT_FIVE,
	output logic [6:0] START_GAIN,
	output logic [3:0] BANDPASS_WIDTH_KHZ,
	// burst tone
	output logic RANGE_SHIFT_X6,
	output logic [15:0] BURST_TONE_DHZ,
	output logic BURST_TONE_CODE_VALID,
	// timing in clock cycles
	output logic [15:0] COMPARATOR_FILTER_CYCLES,
	output logic [15:0] PULSE_GAP_CYCLES,
	// pin and diagnostics
	output logic PIN_IF_ONE_WIRE,
	output logic DIAG_PAGE_SYSTEM,
	output logic PIN_TRANSCEIVER_EN,
	// presets
	output logic [4:0] PRESET1_PULSE_COUNT,
	output logic PRESET1_SINGLE_FIRST,
	output logic [4:0] PRESET2_PULSE_COUNT,
	output logic PRESET2_SINGLE_FIRST,
	output logic [2:0] NODE_ADDRESS
);

	// ==========================================================
	// elaboration checks
	if (DATA_W != 32)
	begin : g_bad_data
		$error("register port must be 32 bits wide");
	end
	if (PULSE_MSB - PULSE_LSB + 1 != 5)
	begin : g_bad_pulse
		$error("preset pulse field must be five bits");
	end
	if (NODE_MSB - NODE_LSB + 1 != 3)
	begin : g_bad_node
		$error("node address field must be three bits");
	end

	// ==========================================================
	// bus handshake
	typedef enum logic [1:0] {
		BCR_IDLE = 2'b01,
		BCR_ACK = 2'b10
	} bcr_state_t;

	bcr_state_t state_r;
	bcr_state_t state_nxt;
	logic [7:0] gain5_r;
	logic [7:0] start_gain_r;
	logic [7:0] tone_r;
	logic [7:0] gap_r;
	logic [7:0] preset1_r;
	logic [7:0] preset2_r;
	logic [7:0] rd_byte;
	logic [7:0] idx;
	logic hit;
	logic do_write;
	logic [DATA_W-1:0] readdata_r;
	logic waitrequest_r;

	// register index from an aligned byte address
	assign idx = {2'b00, ADDRESS[ADDR_W-1:2]};

	// the answer comes one cycle after the request is seen; the extra
	// cycle keeps read data on a flop instead of a mux off the address
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			BCR_IDLE:
				if (READ || WRITE)
					state_nxt = BCR_ACK;
			BCR_ACK:
				state_nxt = BCR_IDLE;
			default:
				state_nxt = BCR_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			state_r <= BCR_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			waitrequest_r <= 1'b1;
		else
			waitrequest_r <= !(state_r == BCR_IDLE && (READ || WRITE));
	end

	// write commits at the edge where the master sees waitrequest low
	assign do_write = (state_r == BCR_ACK) && WRITE && BYTEENABLE[0];

	// ==========================================================
	// read decode; unmapped addresses read zero, writes to them drop
	always_comb
	begin
		rd_byte = 8'h00;
		hit = 1'b1;
		if (idx == IDX_GAIN5)
			rd_byte = gain5_r;
		else if (idx == IDX_START_GAIN)
			rd_byte = start_gain_r;
		else if (idx == IDX_TONE)
			rd_byte = tone_r;
		else if (idx == IDX_GAP)
			rd_byte = gap_r;
		else if (idx == IDX_PRESET1)
			rd_byte = preset1_r;
		else if (idx == IDX_PRESET2)
			rd_byte = preset2_r;
		else
			hit = 1'b0;
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			readdata_r <= 32'h0000_0000;
		else if (state_r == BCR_IDLE && READ)
			readdata_r <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000; // see [RULE17]
	end

	// bus outputs come straight from flops, never from the address mux
	assign READDATA = readdata_r;
	assign WAITREQUEST = waitrequest_r;

	// ==========================================================
	// storage: every bit including the reserved one reads back
	// a write with the low byte lane off is dropped as a whole
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			gain5_r <= REG_RESET; // see [RULE17]
			start_gain_r <= REG_RESET;
			tone_r <= REG_RESET;
			gap_r <= REG_RESET;
			preset1_r <= REG_RESET;
			preset2_r <= REG_RESET;
		end
		else if (do_write)
		begin
			if (idx == IDX_GAIN5)
				gain5_r <= WRITEDATA[7:0]; // see [RULE17]
			else if (idx == IDX_START_GAIN)
				start_gain_r <= WRITEDATA[7:0];
			else if (idx == IDX_TONE)
				tone_r <= WRITEDATA[7:0];
			else if (idx == IDX_GAP)
				gap_r <= WRITEDATA[7:0];
			else if (idx == IDX_PRESET1)
				preset1_r <= WRITEDATA[7:0];
			else if (idx == IDX_PRESET2)
				preset2_r <= WRITEDATA[7:0];
		end
	end

	// ==========================================================
	// gain and filter settings; range offset is added downstream
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			GAIN_POINT_FIVE <= 7'h00;
			START_GAIN <= 7'h00;
			BANDPASS_WIDTH_KHZ <= 4'h0;
		end
		else
		begin
			GAIN_POINT_FIVE <= {1'b0, gain5_r[GAIN5_MSB:GAIN5_LSB]}
				+ 7'h01; // see [RULE1]
			START_GAIN <= {1'b0, start_gain_r[START_MSB:START_LSB]}
				+ 7'h01; // see [RULE4]
			BANDPASS_WIDTH_KHZ <= 4'(BW_STEP_KHZ
				* ({2'b00, start_gain_r[BW_MSB:BW_LSB]} + 4'h1)); // see [RULE3]
		end
	end

	// ==========================================================
	// burst tone
	// the tone path is two flops deep, a cycle behind the plain settings
	logic [15:0] tone_dhz;
	logic tone_valid;

	bcr_tone_calc u_tone (
		.clk(CLOCK),
		.rst_b(RST_B),
		.tone_code(tone_r),
		.shift_x6(gain5_r[SHIFT_BIT]),
		.tone_dhz_r(tone_dhz),
		.code_valid_r(tone_valid)
	);

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			RANGE_SHIFT_X6 <= 1'b0;
			BURST_TONE_DHZ <= 16'h0000;
			BURST_TONE_CODE_VALID <= 1'b0;
		end
		else
		begin
			RANGE_SHIFT_X6 <= gain5_r[SHIFT_BIT]; // see [RULE2]
			BURST_TONE_DHZ <= tone_dhz; // see [RULE5]
			BURST_TONE_CODE_VALID <= tone_valid; // see [RULE6]
		end
	end

	// ==========================================================
	// comparator filter and pulse gap, converted to cycles
	// gap steps are 12.5 cycles; rounding up keeps the gap a true minimum
	function automatic logic [15:0] gap_cycles(input logic [3:0] code);
		int unsigned ps;
		ps = GAP_STEP_PS * code;
		return ps_to_cycles(ps);
	endfunction : gap_cycles

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			COMPARATOR_FILTER_CYCLES <= 16'h0000;
			PULSE_GAP_CYCLES <= 16'h0000;
		end
		else
		begin
			COMPARATOR_FILTER_CYCLES <= 16'(FILT_STEP_CYC
				* {12'h000, gap_r[FILT_MSB:FILT_LSB]}); // see [RULE7]
			PULSE_GAP_CYCLES <= gap_cycles(gap_r[GAPC_MSB:GAPC_LSB]); // see [RULE8]
		end
	end

	// ==========================================================
	// pin interface and diagnostic page
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			PIN_IF_ONE_WIRE <= 1'b0;
			DIAG_PAGE_SYSTEM <= 1'b0;
			PIN_TRANSCEIVER_EN <= 1'b1;
		end
		else
		begin
			PIN_IF_ONE_WIRE <= preset1_r[IFSEL_BIT]; // see [RULE9]
			DIAG_PAGE_SYSTEM <= preset1_r[DIAG_BIT]; // see [RULE10]
			// the off bit is ignored once the one-wire serial mode is on
			PIN_TRANSCEIVER_EN <= !(preset1_r[XOFF_BIT]
				&& !preset1_r[IFSEL_BIT]); // see [RULE11] see [RULE12]
		end
	end

	// ==========================================================
	// preset pulse counts
	// a zero field becomes one pulse; the flag steers it to the first driver
	logic [4:0] p1_pulses;
	logic p1_single;
	logic [4:0] p2_pulses;
	logic p2_single;

	bcr_pulse_decode #(.CNT_W(5)) u_p1 (
		.clk(CLOCK),
		.rst_b(RST_B),
		.count_field(preset1_r[PULSE_MSB:PULSE_LSB]), // see [RULE13]
		.pulses_r(p1_pulses),
		.single_first_r(p1_single)
	);

	bcr_pulse_decode #(.CNT_W(5)) u_p2 (
		.clk(CLOCK),
		.rst_b(RST_B),
		.count_field(preset2_r[PULSE_MSB:PULSE_LSB]), // see [RULE15]
		.pulses_r(p2_pulses),
		.single_first_r(p2_single)
	);

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			PRESET1_PULSE_COUNT <= 5'h00;
			PRESET1_SINGLE_FIRST <= 1'b0;
			PRESET2_PULSE_COUNT <= 5'h00;
			PRESET2_SINGLE_FIRST <= 1'b0;
			NODE_ADDRESS <= 3'h0;
		end
		else
		begin
			PRESET1_PULSE_COUNT <= p1_pulses; // see [RULE13]
			PRESET1_SINGLE_FIRST <= p1_single; // see [RULE14]
			PRESET2_PULSE_COUNT <= p2_pulses; // see [RULE15]
			PRESET2_SINGLE_FIRST <= p2_single; // see [RULE14]
			NODE_ADDRESS <= preset2_r[NODE_MSB:NODE_LSB]; // see [RULE16]
		end
	end

endmodule : bcr_regs

// ===== bcr_regs_properties.sv
// bcr_regs_properties: bus handshake and setting checks for bcr_regs
// assumes the bind below; one clock, reset async active low
`timescale 1ns/1ps
module bcr_regs_chk
	import bcr_pkg::*;
#(
	parameter int DATA_W = 32
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// register bus
	input wire logic [ADDR_W-1:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [DATA_W-1:0] WRITEDATA,
	input wire logic [DATA_W/8-1:0] BYTEENABLE,
	input wire logic [DATA_W-1:0] READDATA,
	input wire logic WAITREQUEST,
	// settings
	input wire logic RANGE_SHIFT_X6,
	input wire logic BURST_TONE_CODE_VALID,
	input wire logic [15:0] COMPARATOR_FILTER_CYCLES,
	input wire logic PIN_IF_ONE_WIRE,
	input wire logic PIN_TRANSCEIVER_EN,
	input wire logic [4:0] PRESET1_PULSE_COUNT,
	input wire logic PRESET1_SINGLE_FIRST
);
	// ==========================================================
	// write taken at the edge where waitrequest is seen low
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	sequence s_wr(logic [5:0] idx);
		WRITE && !WAITREQUEST && BYTEENABLE[0] && ADDRESS[7:2] == idx;
	endsequence
	// ==========================================================
	// properties
	property p_answer;
		(READ || WRITE) && WAITREQUEST |=> !WAITREQUEST;
	endproperty
	property p_release;
		!WAITREQUEST |=> WAITREQUEST;
	endproperty
	property p_idle;
		!READ && !WRITE |=> WAITREQUEST;
	endproperty
	property p_unmapped;
		READ && WAITREQUEST && ADDRESS[7:2] < 6'h1A |=> READDATA == 32'h0;
	endproperty
	property p_shift;
		s_wr(6'h1A) |-> ##2 RANGE_SHIFT_X6 == $past(WRITEDATA[0], 2);
	endproperty
	property p_pin;
		s_wr(6'h1E) |-> ##2 PIN_IF_ONE_WIRE == $past(WRITEDATA[7], 2)
			&& PIN_TRANSCEIVER_EN ==
			!($past(WRITEDATA[5], 2) && !$past(WRITEDATA[7], 2));
	endproperty
	property p_pulse1;
		s_wr(6'h1E) |-> ##3
			PRESET1_SINGLE_FIRST == ($past(WRITEDATA[4:0], 3) == 5'h00)
			&& PRESET1_PULSE_COUNT == (($past(WRITEDATA[4:0], 3) == 5'h00)
			? 5'h01 : $past(WRITEDATA[4:0], 3));
	endproperty
	property p_valid;
		s_wr(6'h1C) |-> ##3
			BURST_TONE_CODE_VALID == ($past(WRITEDATA[7:0], 3) <= 8'hFA);
	endproperty
	property p_filter;
		s_wr(6'h1D) |-> ##2
			COMPARATOR_FILTER_CYCLES == $past(WRITEDATA[7:4], 2) * 16'h0640;
	endproperty
	a_answer: assert property (p_answer)
		else $error("no answer one cycle after request");
	a_release: assert property (p_release)
		else $error("waitrequest low longer than one cycle");
	a_idle: assert property (p_idle)
		else $error("answer without request");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_shift: assert property (p_shift)
		else $error("range shift does not follow write");
	a_pin: assert property (p_pin)
		else $error("pin control does not follow write");
	a_pulse1: assert property (p_pulse1)
		else $error("preset one pulse count wrong");
	a_valid: assert property (p_valid)
		else $error("tone code valid flag wrong");
	a_filter: assert property (p_filter)
		else $error("comparator filter cycles wrong");
endmodule : bcr_regs_chk

bind bcr_regs bcr_regs_chk #(.DATA_W(DATA_W)) u_chk (.CLOCK(CLOCK),
	.RST_B(RST_B), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
	.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
	.WAITREQUEST(WAITREQUEST), .RANGE_SHIFT_X6(RANGE_SHIFT_X6),
	.BURST_TONE_CODE_VALID(BURST_TONE_CODE_VALID),
	.COMPARATOR_FILTER_CYCLES(COMPARATOR_FILTER_CYCLES),
	.PIN_IF_ONE_WIRE(PIN_IF_ONE_WIRE),
	.PIN_TRANSCEIVER_EN(PIN_TRANSCEIVER_EN),
	.PRESET1_PULSE_COUNT(PRESET1_PULSE_COUNT),
	.PRESET1_SINGLE_FIRST(PRESET1_SINGLE_FIRST));

// ===== bcr_regs_tb_top.sv
// bcr_regs_tb_top: self-checking bench for the configuration bank
// assumes bcr_pkg and bcr_regs compiled first; bench is the bus master
`timescale 1ns/1ps
module bcr_regs_tb_top;
	// ==========================================================
	// stimulus and observed signals
	logic clk, rst_b, rd_req, wr_req, waitreq, shift, tval;
	logic ifsel, diag, xen, p1s, p2s;
	logic [7:0] address;
	logic [31:0] wdata, rdata, rdv;
	logic [3:0] ben, bw;
	logic [6:0] gp5, sg;
	logic [15:0] tone, filt, gap;
	logic [4:0] p1c, p2c;
	logic [2:0] node;
	int fail_count = 0;
	int n_checks = 0;

	bcr_regs dut (.CLOCK(clk), .RST_B(rst_b), .ADDRESS(address),
		.READ(rd_req), .WRITE(wr_req), .WRITEDATA(wdata),
		.BYTEENABLE(ben), .READDATA(rdata), .WAITREQUEST(waitreq),
		.GAIN_POINT_FIVE(gp5), .START_GAIN(sg), .BANDPASS_WIDTH_KHZ(bw),
		.RANGE_SHIFT_X6(shift), .BURST_TONE_DHZ(tone),
		.BURST_TONE_CODE_VALID(tval), .COMPARATOR_FILTER_CYCLES(filt),
		.PULSE_GAP_CYCLES(gap), .PIN_IF_ONE_WIRE(ifsel),
		.DIAG_PAGE_SYSTEM(diag), .PIN_TRANSCEIVER_EN(xen),
		.PRESET1_PULSE_COUNT(p1c), .PRESET1_SINGLE_FIRST(p1s),
		.PRESET2_PULSE_COUNT(p2c), .PRESET2_SINGLE_FIRST(p2s),
		.NODE_ADDRESS(node));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// shared tasks
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	task check(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// request held until waitrequest is sampled low; bounded wait
	task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
		input logic be);
		int n;
		n = 0;
		@(posedge clk);
		address <= {idx, 2'h0};
		rd_req <= ~wr;
		wr_req <= wr;
		wdata <= {24'h000000, d};
		ben <= {3'h0, be};
		@(posedge clk);
		while (waitreq !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		rdv = rdata;
		rd_req <= 1'b0;
		wr_req <= 1'b0;
		if (n >= 20)
		begin
			fail_count++;
			summarize();
		end
	endtask : bus

	task rdchk(input logic [5:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00, 1'b1);
		check("readdata", rdv, {24'h000000, exp});
	endtask : rdchk

	// settings lag a write by up to three edges
	task settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle

	// ==========================================================
	// scenarios
	task t_reset;
		for (int i = 0; i < 6; i++)
			rdchk(6'h1A + i[5:0], 8'h00);
		check("gain5", gp5, 32'h1);
		check("start", sg, 32'h1);
		check("bw", bw, 32'h2);
		check("tone", tone, 32'h12C);
		check("xcvr", xen, 32'h1);
		check("p1", {p1s, p1c}, 32'h21);
		check("p2", {p2s, p2c}, 32'h21);
		check("node", node, 32'h0);
	endtask : t_reset

	task t_rw;
		logic [7:0] v[6] = '{8'hA6, 8'h7D, 8'h5A, 8'hC3, 8'h96, 8'hE9};
		for (int i = 0; i < 6; i++)
			bus(1'b1, 6'h1A + i[5:0], v[i], 1'b1);
		for (int i = 0; i < 6; i++)
			rdchk(6'h1A + i[5:0], v[i]);
		bus(1'b1, 6'h1C, 8'hFF, 1'b0);
		rdchk(6'h1C, 8'h5A);
		bus(1'b1, 6'h19, 8'hFF, 1'b1);
		rdchk(6'h19, 8'h00);
		rdchk(6'h20, 8'h00);
	endtask : t_rw

	task t_gain;
		bus(1'b1, 6'h1A, 8'hFE, 1'b1);
		bus(1'b1, 6'h1B, 8'hFF, 1'b1);
		settle();
		check("gain5", gp5, 32'h40);
		check("bw", bw, 32'h8);
		check("start", sg, 32'h40);
		bus(1'b1, 6'h1B, 8'h41, 1'b1);
		settle();
		check("bw", bw, 32'h4);
		check("start", sg, 32'h2);
	endtask : t_gain

	task t_tone;
		logic [7:0] c[4] = '{8'h00, 8'hFA, 8'hFB, 8'hFF};
		int e;
		for (int s = 0; s < 2; s++)
			for (int i = 0; i < 4; i++)
			begin
				bus(1'b1, 6'h1A, {7'h00, s[0]}, 1'b1);
				bus(1'b1, 6'h1C, c[i], 1'b1);
				settle();
				e = (2 * c[i] + 300) * (s ? 6 : 1);
				check("tone", tone, e);
				check("shift", shift, s[0]);
				check("valid", tval, c[i] <= 8'hFA);
			end
	endtask : t_tone

	task t_gap;
		int n[3] = '{1, 8, 15};
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b1, 6'h1D, {n[i][3:0], n[i][3:0]}, 1'b1);
			settle();
			check("filter", filt, n[i] * 1600);
			check("gap", gap, (n[i] * 25 + 1) / 2);
		end
	endtask : t_gap

	task t_pin;
		logic [4:0] f;
		for (int v = 0; v < 8; v++)
		begin
			f = {v[2:0], 2'h0};
			bus(1'b1, 6'h1E, {v[2:0], f}, 1'b1);
			settle();
			check("ifsel", ifsel, v[2]);
			check("diag", diag, v[1]);
			check("xcvr", xen, !(v[0] && !v[2]));
			check("p1", p1c, f == 5'h00 ? 5'h01 : f);
			check("p1single", p1s, f == 5'h00);
		end
	endtask : t_pin

	task t_preset2;
		bus(1'b1, 6'h1F, 8'hE0, 1'b1);
		settle();
		check("node", node, 32'h7);
		check("p2", {p2s, p2c}, 32'h21);
		bus(1'b1, 6'h1F, 8'h3F, 1'b1);
		settle();
		check("node", node, 32'h1);
		check("p2", {p2s, p2c}, 32'h1F);
	endtask : t_preset2

	// ==========================================================
	// main sequence
	initial
	begin
		rst_b = 1'b0;
		rd_req = 1'b0;
		wr_req = 1'b0;
		address = 8'h00;
		wdata = 32'h0;
		ben = 4'h0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		settle();
		t_reset();
		t_rw();
		t_gain();
		t_tone();
		t_gap();
		t_pin();
		t_preset2();
		summarize();
	end
endmodule : bcr_regs_tb_top

// ===== bcr_tone_calc.sv
// bcr_tone_calc: burst tone frequency in 100 Hz units from the code
// assumes code and shift come from registers on the same clock
`timescale 1ns/1ps
module bcr_tone_calc
	import bcr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// settings
	input wire logic [7:0] tone_code,
	input wire logic shift_x6,
	// result
	output logic [15:0] tone_dhz_r,
	output logic code_valid_r
);

	logic [12:0] base_dhz;

	// ==========================================================
	// 0.2 kHz per step plus 30 kHz; 13 bits hold 255 * 2 + 300
	assign base_dhz = TONE_STEP_DHZ * {5'h00, tone_code}
		+ TONE_BASE_DHZ; // see [RULE5]

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tone_dhz_r <= 16'h0000;
			code_valid_r <= 1'b0;
		end
		else
		begin
			// range shift multiplies the computed tone by six
			if (shift_x6)
				tone_dhz_r <= 16'(base_dhz * TONE_SHIFT_MUL); // see [RULE2]
			else
				tone_dhz_r <= {3'h0, base_dhz}; // see [RULE2]
			// codes above the top are software's fault; flag, do not clamp
			code_valid_r <= (tone_code <= TONE_CODE_MAX); // see [RULE6]
		end
	end

endmodule : bcr_tone_calc
